// ---- pkg/hb_pkg.sv ----
`default_nettype none
package hb_pkg;
	// Clock
	localparam int CLK_MHZ = 10;

	// Register byte offsets
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] CFG_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] GATE_OFS = 4'hC;

	// Control register fields
	localparam int EN_BIT = 0;
	localparam int OLA_BIT = 1;
	localparam int OLB_BIT = 2;
	localparam int OLTH_BIT = 3;
	localparam int STBY_BIT = 4;

	// Configuration register fields
	localparam int SLEW_LSB = 0;
	localparam int CCPA_LSB = 8;
	localparam int CCPB_LSB = 12;
	localparam int THR_LSB = 16;

	// Status register fields
	localparam int DS_LSB = 0;
	localparam int OLF_LSB = 4;
	localparam int DIAG_LSB = 8;
	localparam int FAIL_LSB = 12;
	localparam int SINK_BIT = 15;
	localparam int STATE_LSB = 16;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;

	// Driver indices
	localparam logic [1:0] DRV_HA = 2'h0;
	localparam logic [1:0] DRV_LA = 2'h1;
	localparam logic [1:0] DRV_HB = 2'h2;
	localparam logic [1:0] DRV_LB = 2'h3;

	// Slew current: gate current = code * (max current / SLEW_STEPS)
	localparam int SLEW_STEPS = 31;

	// Timing
	localparam int SINK_MIN_US = 32;
	localparam int SINK_MAX_US = 64;
	localparam int SINK_CYC = SINK_MIN_US * CLK_MHZ;
	localparam int SC_FILTER_NS = 6000;
	localparam int SC_CYC = (SC_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int OL_FILTER_NS = 200000;
	localparam int OL_CYC = (OL_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int CCP_STEP_NS = 500;
	localparam int CCP_STEP_CYC = (CCP_STEP_NS * CLK_MHZ + 999) / 1000;

	// Off-mode diagnosis result codes
	localparam logic [2:0] DIAG_NONE = 3'h0;
	localparam logic [2:0] DIAG_OPEN_A = 3'h1;
	localparam logic [2:0] DIAG_OPEN_B = 3'h2;
	localparam logic [2:0] DIAG_SHORT_GND = 3'h3;
	localparam logic [2:0] DIAG_SHORT_VS = 3'h4;

	typedef enum logic [2:0] {
		S_OFF = 3'b000,
		S_HS_WAIT = 3'b001,
		S_HS_ON = 3'b010,
		S_HS_LOCK = 3'b011,
		S_LS_LOCK = 3'b100,
		S_LS_ON = 3'b101
	} pwm_state_t;

	typedef struct packed {
		logic [3:0] on;
		logic [3:0] sink;
		logic [3:0] rl;
	} gate_cmd_t;
endpackage
`default_nettype wire

// ---- rtl/hbridge_gate_drive_control.sv ----
// What this block does
// (RULE1) Slew on: high-side current source below threshold
// (RULE2) Gate current is slew code times step
// (RULE3) Slew code zero uses low-impedance switch
// (RULE4) Standby or failures force resistive-low mode
// (RULE5) Failure entry: sink 32-64 us, then resistive
// (RULE6) Sink phase is slew limited when enabled
// (RULE7) Filtered drain-source overvoltage turns gate off
// (RULE8) Fault flag holds gate off until cleared
// (RULE9) Monitoring only while gate on, filtered
// (RULE10) Per-driver threshold select drives comparators
// (RULE11) Off-diag bits with enable give resistive-low
// (RULE12) Low drain-source voltage filtered sets flag
// (RULE13) Off-diag disabled keeps low-side flags clear
// (RULE14) Decode off-mode flags into fault result
// (RULE15) Switch-on delayed by cross-current time
// (RULE16) Four-bit per-leg code sets lock delay
// (RULE17) Two lock timers share one duration
// (RULE18) PWM sequence: HS off, LS on, HS on
// (RULE19) Host drives direction and PWM inputs
// (RULE20) Timers restart when trigger ends early
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none
module hbridge_gate_drive_control
	import hb_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [3:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Bridge control pins
	input wire logic bridge_pwm_input_i,
	input wire logic bridge_direction_input_i,
	// Analog comparators
	input wire logic [3:0] ds_over_threshold_i,
	input wire logic [1:0] ls_below_sixth_i,
	input wire logic [1:0] hs_below_switch_i,
	// Device failure flags
	input wire logic thermal_shutdown_flag_i,
	input wire logic pump_voltage_low_flag_i,
	input wire logic invalid_command_flag_i,
	// Gate driver controls
	output gate_cmd_t gate_cmd_o,
	output logic [1:0] hs_current_source_o,
	output logic [4:0] gate_current_code_o,
	output logic [7:0] short_threshold_select_o
);
	localparam int SINK_W = $clog2(SINK_CYC + 1);
	localparam int SC_W = $clog2(SC_CYC + 1);
	localparam int OL_W = $clog2(OL_CYC + 1);

	logic [31:0] ctrl_q;
	logic [31:0] cfg_q;
	logic wreq_q;
	logic [31:0] rdata_q;
	logic [9:0] meta_q;
	logic [9:0] sync_q;
	logic pwm_s;
	logic dir_s;
	logic [3:0] ds_s;
	logic [1:0] ol_s;
	logic [1:0] hsb_s;
	logic pwm_prev_q;
	logic dir_prev_q;
	logic fail;
	logic offdiag_act;
	logic rl_mode;
	logic rl_q;
	logic sink_act_q;
	logic [SINK_W-1:0] sink_cnt_q;
	logic [3:0] ds_flag_q;
	logic [SC_W-1:0] sc_cnt_q [4];
	logic [1:0] olf_q;
	logic [OL_W-1:0] ol_cnt_q [2];
	logic [2:0] diag_d;
	pwm_state_t pwm_st_q;
	logic [7:0] tmr1_q;
	logic [7:0] tmr2_q;
	logic [7:0] lock_cyc;
	logic pwm_rise;
	logic accept;
	logic wr_acc;
	logic [3:0] ds_clr;
	logic [1:0] olf_clr;
	gate_cmd_t cmd_d;
	gate_cmd_t gate_cmd_q;
	logic [1:0] hs_cs_d;
	logic [31:0] rdata_d;
	logic [1:0] hs_idx;
	logic [1:0] ls_idx;
	logic [1:0] opp_idx;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Avalon slave: one wait cycle per access
	assign accept = (read_i || write_i) && !wreq_q;
	assign wr_acc = write_i && !wreq_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wreq_q <= 1'b1;
		end else begin
			wreq_q <= !((read_i || write_i) && wreq_q);
		end
	end

	always_comb begin
		case (address_i)
			CTRL_OFS: rdata_d = ctrl_q;
			CFG_OFS: rdata_d = cfg_q;
			STATUS_OFS: begin
				rdata_d = 32'h0000_0000;
				rdata_d[DS_LSB +: 4] = ds_flag_q;
				rdata_d[OLF_LSB +: 2] = olf_q;
				rdata_d[DIAG_LSB +: 3] = diag_d;
				rdata_d[FAIL_LSB +: 3] = {invalid_command_flag_i, pump_voltage_low_flag_i,
					thermal_shutdown_flag_i};
				rdata_d[SINK_BIT] = sink_act_q;
				rdata_d[STATE_LSB +: 3] = pwm_st_q;
			end
			GATE_OFS: rdata_d = {20'h0_0000, gate_cmd_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (read_i && wreq_q) begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			cfg_q <= CFG_RST;
		end else if (wr_acc) begin
			if (address_i == CTRL_OFS) begin
				ctrl_q <= be_merge(ctrl_q, writedata_i, byteenable_i) & 32'h0000_001F;
			end
			if (address_i == CFG_OFS) begin
				cfg_q <= be_merge(cfg_q, writedata_i, byteenable_i) & 32'h00FF_FF1F;
			end
		end
	end

	assign ds_clr = (wr_acc && address_i == STATUS_OFS && byteenable_i[0]) ?
		writedata_i[DS_LSB +: 4] : 4'h0;
	assign olf_clr = (wr_acc && address_i == STATUS_OFS && byteenable_i[0]) ?
		writedata_i[OLF_LSB +: 2] : 2'h0;

	// Pin and comparator synchronisers
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 10'h000;
			sync_q <= 10'h000;
		end else begin
			meta_q <= {hs_below_switch_i, ls_below_sixth_i, ds_over_threshold_i,
				bridge_direction_input_i, bridge_pwm_input_i};
			sync_q <= meta_q;
		end
	end
	assign pwm_s = sync_q[0];
	assign dir_s = sync_q[1];
	assign ds_s = sync_q[5:2];
	assign ol_s = sync_q[7:6];
	assign hsb_s = sync_q[9:8];

	// Resistive-low entry and sink phase
	assign fail = thermal_shutdown_flag_i || pump_voltage_low_flag_i || invalid_command_flag_i;
	assign offdiag_act = ctrl_q[EN_BIT] && (ctrl_q[OLA_BIT] || ctrl_q[OLB_BIT]); // (RULE11)
	assign rl_mode = !ctrl_q[EN_BIT] || ctrl_q[STBY_BIT] || fail || offdiag_act; // (RULE4)

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rl_q <= 1'b1;
			sink_act_q <= 1'b0;
			sink_cnt_q <= '0;
		end else begin
			rl_q <= rl_mode;
			if (fail && !rl_q) begin
				sink_act_q <= 1'b1; // (RULE5)
				sink_cnt_q <= '0;
			end else if (sink_act_q) begin
				if (!fail) begin
					sink_act_q <= 1'b0; // (RULE20)
					sink_cnt_q <= '0;
				end else if (sink_cnt_q == SINK_W'(SINK_CYC - 1)) begin
					sink_act_q <= 1'b0; // (RULE5)
				end else begin
					sink_cnt_q <= sink_cnt_q + SINK_W'(1);
				end
			end
		end
	end

	// Drain-source short monitoring
	for (genvar i = 0; i < 4; i++) begin : g_ds
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				sc_cnt_q[i] <= '0;
				ds_flag_q[i] <= 1'b0;
			end else begin
				if (gate_cmd_q.on[i] && ds_s[i]) begin // (RULE9)
					if (sc_cnt_q[i] != SC_W'(SC_CYC - 1)) begin
						sc_cnt_q[i] <= sc_cnt_q[i] + SC_W'(1);
					end
				end else begin
					sc_cnt_q[i] <= '0; // (RULE20)
				end
				if (gate_cmd_q.on[i] && ds_s[i] && sc_cnt_q[i] == SC_W'(SC_CYC - 1)) begin
					ds_flag_q[i] <= 1'b1; // (RULE7)
				end else if (ds_clr[i]) begin
					ds_flag_q[i] <= 1'b0; // (RULE8)
				end
			end
		end
	end

	// Off-mode diagnosis of the low-side legs
	for (genvar k = 0; k < 2; k++) begin : g_ol
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				ol_cnt_q[k] <= '0;
				olf_q[k] <= 1'b0;
			end else if (!offdiag_act) begin
				ol_cnt_q[k] <= '0;
				olf_q[k] <= 1'b0; // (RULE13)
			end else begin
				if (ol_s[k]) begin
					if (ol_cnt_q[k] != OL_W'(OL_CYC - 1)) begin
						ol_cnt_q[k] <= ol_cnt_q[k] + OL_W'(1);
					end
				end else begin
					ol_cnt_q[k] <= '0; // (RULE20)
				end
				if (ol_s[k] && ol_cnt_q[k] == OL_W'(OL_CYC - 1)) begin
					olf_q[k] <= 1'b1; // (RULE12)
				end else if (olf_clr[k]) begin
					olf_q[k] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		diag_d = DIAG_NONE;
		if (offdiag_act) begin
			if (olf_q[0] && olf_q[1]) begin
				diag_d = ctrl_q[OLTH_BIT] ? DIAG_SHORT_VS : DIAG_SHORT_GND; // (RULE14)
			end else if (ctrl_q[OLA_BIT] && olf_q[1] && !ctrl_q[OLTH_BIT]) begin
				diag_d = DIAG_OPEN_B; // (RULE14)
			end else if (ctrl_q[OLB_BIT] && olf_q[0] && !ctrl_q[OLTH_BIT]) begin
				diag_d = DIAG_OPEN_A; // (RULE14)
			end
		end
	end

	// PWM leg sequencing with two lock timers
	assign hs_idx = dir_s ? DRV_HA : DRV_HB;
	assign ls_idx = dir_s ? DRV_LA : DRV_LB;
	assign opp_idx = dir_s ? DRV_LB : DRV_LA;
	assign lock_cyc = 8'((dir_s ? cfg_q[CCPA_LSB +: 4] : cfg_q[CCPB_LSB +: 4]) + 5'd1)
		* 8'(CCP_STEP_CYC); // (RULE16)
	assign pwm_rise = pwm_s && !pwm_prev_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_prev_q <= 1'b0;
			dir_prev_q <= 1'b0;
		end else begin
			pwm_prev_q <= pwm_s;
			dir_prev_q <= dir_s;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_st_q <= S_OFF;
			tmr1_q <= 8'h00;
			tmr2_q <= 8'h00;
		end else if (rl_mode || dir_s != dir_prev_q) begin
			pwm_st_q <= S_OFF;
			tmr1_q <= 8'h00;
			tmr2_q <= 8'h00;
		end else begin
			case (pwm_st_q)
				S_OFF: begin
					pwm_st_q <= S_HS_WAIT;
					tmr2_q <= 8'h00;
				end
				S_HS_WAIT: begin
					if (tmr2_q == lock_cyc - 8'd1) begin
						pwm_st_q <= S_HS_ON; // (RULE15)
					end else begin
						tmr2_q <= tmr2_q + 8'd1;
					end
				end
				S_HS_ON: begin
					if (!pwm_s) begin
						pwm_st_q <= S_HS_LOCK; // (RULE18)
						tmr1_q <= 8'h00;
					end
				end
				S_HS_LOCK: begin
					if (pwm_s) begin
						pwm_st_q <= S_HS_ON; // (RULE20)
					end else if (tmr1_q == lock_cyc - 8'd1) begin
						pwm_st_q <= S_LS_LOCK; // (RULE17)
						tmr1_q <= 8'h00;
					end else begin
						tmr1_q <= tmr1_q + 8'd1;
					end
				end
				S_LS_LOCK: begin
					if (pwm_rise) begin
						pwm_st_q <= S_HS_WAIT;
						tmr2_q <= 8'h00;
					end else if (tmr1_q == lock_cyc - 8'd1) begin
						pwm_st_q <= S_LS_ON; // (RULE18)
					end else begin
						tmr1_q <= tmr1_q + 8'd1;
					end
				end
				S_LS_ON: begin
					if (pwm_rise) begin
						pwm_st_q <= S_HS_WAIT; // (RULE18)
						tmr2_q <= 8'h00;
					end
				end
				default: pwm_st_q <= S_OFF;
			endcase
		end
	end

	// Gate commands
	always_comb begin
		cmd_d = '{on: 4'h0, sink: 4'h0, rl: 4'h0};
		if (rl_mode) begin
			if (sink_act_q || (fail && !rl_q)) begin
				cmd_d.sink = 4'hF; // (RULE5)
			end else begin
				cmd_d.rl = 4'hF; // (RULE4)
			end
		end else begin
			if (pwm_st_q == S_HS_ON || pwm_st_q == S_HS_LOCK) begin
				cmd_d.on[hs_idx] = 1'b1;
			end
			if (pwm_st_q == S_LS_ON) begin
				cmd_d.on[ls_idx] = 1'b1;
			end
			if (pwm_st_q != S_OFF) begin
				cmd_d.on[opp_idx] = 1'b1;
			end
		end
		cmd_d.on = cmd_d.on & ~ds_flag_q; // (RULE8)
		hs_cs_d = 2'h0;
		if (cfg_q[SLEW_LSB +: 5] != 5'h00) begin // (RULE3)
			hs_cs_d[0] = hsb_s[0] && (cmd_d.on[DRV_HA] || cmd_d.sink[DRV_HA]); // (RULE1)
			hs_cs_d[1] = hsb_s[1] && (cmd_d.on[DRV_HB] || cmd_d.sink[DRV_HB]); // (RULE6)
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			gate_cmd_q <= '{on: 4'h0, sink: 4'h0, rl: 4'hF};
			hs_current_source_o <= 2'h0;
			gate_current_code_o <= 5'h00;
			short_threshold_select_o <= 8'h00;
		end else begin
			gate_cmd_q <= cmd_d;
			hs_current_source_o <= hs_cs_d;
			gate_current_code_o <= cfg_q[SLEW_LSB +: 5]; // (RULE2)
			short_threshold_select_o <= cfg_q[THR_LSB +: 8]; // (RULE10)
		end
	end

	assign gate_cmd_o = gate_cmd_q;
	assign readdata_o = rdata_q;
	assign waitrequest_o = wreq_q;

	// Checks
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence s_pwm_fall;
		pwm_st_q == S_HS_ON && !pwm_s && !rl_mode && dir_s == dir_prev_q;
	endsequence
	sequence s_lock_done;
		pwm_st_q == S_LS_LOCK && tmr1_q == lock_cyc - 8'd1 && !pwm_rise && !rl_mode
			&& dir_s == dir_prev_q;
	endsequence

	property p_slew_off;
		cfg_q[SLEW_LSB +: 5] == 5'h00 |=> hs_current_source_o == 2'h0;
	endproperty
	a_slew_off: assert property (p_slew_off) else $error("current source while slew off"); // RULE3

	property p_sink_end;
		sink_act_q && fail && sink_cnt_q == SINK_W'(SINK_CYC - 1) |=> ##1 gate_cmd_o.rl == 4'hF;
	endproperty
	a_sink_end: assert property (p_sink_end) else $error("no resistive mode after sink"); // RULE5

	property p_sink_count;
		sink_act_q |-> sink_cnt_q < SINK_W'(SINK_CYC);
	endproperty
	a_sink_count: assert property (p_sink_count) else $error("sink phase overran"); // RULE5

	property p_ds_trip;
		gate_cmd_q.on[0] && ds_s[0] && sc_cnt_q[0] == SC_W'(SC_CYC - 1) |=> ##1 ds_flag_q[0]
			&& !gate_cmd_o.on[0];
	endproperty
	a_ds_trip: assert property (p_ds_trip) else $error("short not tripped"); // RULE7

	property p_ds_hold;
		ds_flag_q[0] && !ds_clr[0] |=> ds_flag_q[0] && !gate_cmd_o.on[0];
	endproperty
	a_ds_hold: assert property (p_ds_hold) else $error("fault flag lost"); // RULE8

	property p_disabled_rl;
		!ctrl_q[EN_BIT] |=> gate_cmd_o.on == 4'h0 && (gate_cmd_o.rl | gate_cmd_o.sink) == 4'hF;
	endproperty
	a_disabled_rl: assert property (p_disabled_rl) else $error("gates active while off"); // RULE4

	property p_offdiag_clear;
		!(ctrl_q[OLA_BIT] || ctrl_q[OLB_BIT]) |=> olf_q == 2'h0;
	endproperty
	a_offdiag_clear: assert property (p_offdiag_clear) else $error("low flag set"); // RULE13

	property p_hs_lock;
		s_pwm_fall |=> pwm_st_q == S_HS_LOCK && tmr1_q == 8'h00 ##1 gate_cmd_o.on[hs_idx]
			|| ds_flag_q[hs_idx] || rl_mode;
	endproperty
	a_hs_lock: assert property (p_hs_lock) else $error("high side dropped early"); // RULE18

	property p_ls_on;
		s_lock_done |=> pwm_st_q == S_LS_ON;
	endproperty
	a_ls_on: assert property (p_ls_on) else $error("low side not switched on"); // RULE18

	property p_bus;
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest timing wrong");
endmodule
`default_nettype wire

// ---- test/bridge_model.sv ----
`default_nettype none
module bridge_model
	import hb_pkg::*;
(
	// Gate commands from the block
	input wire gate_cmd_t gate_cmd_i,
	// Fault injection from the bench
	input wire logic [3:0] short_inject_i,
	input wire logic [1:0] low_sixth_inject_i,
	// Comparator outputs
	output logic [3:0] ds_over_threshold_o,
	output logic [1:0] ls_below_sixth_o,
	output logic [1:0] hs_below_switch_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A shorted transistor shows overvoltage only while it is driven on
	assign ds_over_threshold_o = gate_cmd_i.on & short_inject_i;
	// Off-state low-side voltage is only meaningful under resistive-low bias
	assign ls_below_sixth_o = {gate_cmd_i.rl[3], gate_cmd_i.rl[1]} & low_sixth_inject_i;
	// High side stays below switch threshold while it is driven on or sunk
	assign hs_below_switch_o = {gate_cmd_i.on[2] | gate_cmd_i.sink[2],
		gate_cmd_i.on[0] | gate_cmd_i.sink[0]};
endmodule
`default_nettype wire

// ---- test/hbridge_gate_drive_control_bench.sv ----
`default_nettype none
module hbridge_gate_drive_control_bench import hb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LK = 16 * CCP_STEP_CYC;
	logic clock_i, rst_i, read_i, write_i, pwm, dir, therm, pump, inv;
	logic [3:0] address_i, byteenable_i, short_inj, ds_over;
	logic [31:0] writedata_i, readdata_o, rdata;
	logic [1:0] ol_inj, ls_below, hs_below, hs_src;
	logic waitrequest_o;
	gate_cmd_t gate_cmd_o;
	logic [4:0] code;
	logic [7:0] thr;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	hbridge_gate_drive_control dut (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.bridge_pwm_input_i(pwm), .bridge_direction_input_i(dir),
		.ds_over_threshold_i(ds_over), .ls_below_sixth_i(ls_below),
		.hs_below_switch_i(hs_below), .thermal_shutdown_flag_i(therm),
		.pump_voltage_low_flag_i(pump), .invalid_command_flag_i(inv),
		.gate_cmd_o(gate_cmd_o), .hs_current_source_o(hs_src),
		.gate_current_code_o(code), .short_threshold_select_o(thr));

	bridge_model model (.gate_cmd_i(gate_cmd_o), .short_inject_i(short_inj),
		.low_sixth_inject_i(ol_inj), .ds_over_threshold_o(ds_over),
		.ls_below_sixth_o(ls_below), .hs_below_switch_o(hs_below));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
	endtask

	// One Avalon access; holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_i);
		address_i <= a;
		read_i <= !w;
		write_i <= w;
		writedata_i <= d;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (waitrequest_o !== 1'b0 && k < 20);
		rdata = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		if (k >= 20) begin
			chk(32'h0, 32'h1);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdata & m, e);
	endtask

	// Counts cycles until one gate command bit reaches a level
	task automatic waitg(input int b, input logic v);
		n = 0;
		while (gate_cmd_o[b] !== v && n < 2000) begin
			@(posedge clock_i);
			n++;
		end
	endtask

	task automatic rng(input int lo, input int hi);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	initial begin
		rst_i = 1'b1;
		{read_i, write_i, pwm, dir, therm, pump, inv} = 7'h00;
		address_i = 4'h0;
		writedata_i = 32'h0;
		byteenable_i = 4'hF;
		short_inj = 4'h0;
		ol_inj = 2'h0;
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk({20'h0, gate_cmd_o}, 32'h0000_000F);
		rd(CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
		rd(CFG_OFS, 32'hFFFF_FFFF, CFG_RST);
		wr(4'h2, 32'hFFFF_FFFF);
		rd(4'h2, 32'hFFFF_FFFF, 32'h0);
		// Slew off, both lock codes at maximum, threshold pattern
		wr(CFG_OFS, 32'h00A5_FF00);
		cyc(2);
		chk({24'h0, thr}, 32'h0000_00A5);
		rd(CFG_OFS, 32'hFFFF_FFFF, 32'h00A5_FF00);
		dir <= 1'b1;
		pwm <= 1'b1;
		wr(CTRL_OFS, 32'h0000_0001);
		waitg(8, 1'b1);
		rng(LK, LK + 6);
		chk({28'h0, gate_cmd_o.on}, 32'h0000_0009);
		chk({30'h0, hs_src}, 32'h0);
		wr(CFG_OFS, 32'h00A5_FF1F);
		cyc(3);
		chk({27'h0, code}, 32'h0000_001F);
		chk({30'h0, hs_src}, 32'h0000_0001);
		// PWM low then high
		pwm <= 1'b0;
		waitg(8, 1'b0);
		rng(LK, LK + 6);
		waitg(9, 1'b1);
		rng(LK - 2, LK + 4);
		pwm <= 1'b1;
		waitg(8, 1'b1);
		rng(LK, LK + 8);
		// Interrupted overvoltage must not trip
		short_inj <= 4'h1;
		cyc(40);
		short_inj <= 4'h0;
		cyc(3);
		short_inj <= 4'h1;
		cyc(40);
		short_inj <= 4'h0;
		chk({31'h0, gate_cmd_o[8]}, 32'h1);
		cyc(5);
		short_inj <= 4'h1;
		waitg(8, 1'b0);
		rng(SC_CYC, SC_CYC + 5);
		short_inj <= 4'h0;
		cyc(100);
		chk({31'h0, gate_cmd_o[8]}, 32'h0);
		rd(STATUS_OFS, 32'h0000_000F, 32'h0000_0001);
		wr(STATUS_OFS, 32'h0000_0001);
		waitg(8, 1'b1);
		rng(1, LK + 10);
		rd(STATUS_OFS, 32'h0000_000F, 32'h0);
		// Each failure source: sink phase then resistive-low
		for (int f = 0; f < 3; f++) begin
			{inv, pump, therm} <= 3'b001 << f;
			waitg(4, 1'b1);
			rng(0, 3);
			chk({28'h0, gate_cmd_o.sink}, 32'h0000_000F);
			cyc(4);
			chk({30'h0, hs_src}, 32'h0000_0003);
			waitg(4, 1'b0);
			rng(SINK_CYC - 4, 2 * SINK_CYC - 4);
			chk({20'h0, gate_cmd_o}, 32'h0000_000F);
			rd(STATUS_OFS, 32'h0000_7000, 32'h0000_1000 << f);
			{inv, pump, therm} <= 3'b000;
			waitg(8, 1'b1);
			rng(1, LK + 10);
		end
		wr(CTRL_OFS, 32'h0000_0011);
		cyc(3);
		chk({20'h0, gate_cmd_o}, 32'h0000_000F);
		// Off-mode diagnosis
		wr(CTRL_OFS, 32'h0000_0003);
		cyc(3);
		chk({20'h0, gate_cmd_o}, 32'h0000_000F);
		ol_inj <= 2'b10;
		cyc(OL_CYC + 10);
		rd(STATUS_OFS, 32'h0000_0730, {21'h0, DIAG_OPEN_B, 8'h20});
		ol_inj <= 2'b11;
		cyc(OL_CYC + 10);
		rd(STATUS_OFS, 32'h0000_0730, {21'h0, DIAG_SHORT_GND, 8'h30});
		wr(CTRL_OFS, 32'h0000_000B);
		cyc(3);
		rd(STATUS_OFS, 32'h0000_0730, {21'h0, DIAG_SHORT_VS, 8'h30});
		ol_inj <= 2'b01;
		wr(CTRL_OFS, 32'h0000_0005);
		wr(STATUS_OFS, 32'h0000_0030);
		cyc(OL_CYC + 10);
		rd(STATUS_OFS, 32'h0000_0730, {21'h0, DIAG_OPEN_A, 8'h10});
		// Diagnosis off keeps low-side flags clear
		wr(CTRL_OFS, 32'h0000_0000);
		wr(STATUS_OFS, 32'h0000_0030);
		ol_inj <= 2'b11;
		cyc(OL_CYC + 10);
		rd(STATUS_OFS, 32'h0000_0030, 32'h0);
		// Opposite direction drives leg B high side and leg A low side
		dir <= 1'b0;
		wr(CTRL_OFS, 32'h0000_0001);
		waitg(10, 1'b1);
		rng(LK, LK + 6);
		chk({28'h0, gate_cmd_o.on}, 32'h0000_0006);
		cyc(3);
		chk({30'h0, hs_src}, 32'h0000_0002);
		end_of_test();
	end
endmodule
`default_nettype wire
